// File: fsp_cmd_rx.sv
// Serial command receiver running on the host's serial clock.
`timescale 1ns/10ps
module fsp_cmd_rx (
  input  wire logic        spi_sclk_in,
  input  wire logic        spi_cs_n_in,
  input  wire logic        spi_si_in,
  output logic [31:0]      code_out,
  output logic             code_ok_out
);
  import fsp_pkg::*;

  logic [30:0]             shift_reg;
  logic [BIT_CNT_W-1:0]    cnt_reg;

  // Bits shift in MSB first on the rising edge; deselect clears the frame,
  // since this clock stops between frames and no edge follows the last bit.
  always_ff @(posedge spi_sclk_in or posedge spi_cs_n_in) begin
    if (spi_cs_n_in) begin
      shift_reg <= '0;
      cnt_reg   <= '0;
    end else begin
      shift_reg <= {shift_reg[29:0], spi_si_in};
      if (cnt_reg != BIT_CNT_W'(CMD_BITS)) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  // The level is high only while exactly thirty-two bits have arrived.
  always_ff @(posedge spi_sclk_in or posedge spi_cs_n_in) begin
    if (spi_cs_n_in) begin
      code_ok_out <= 1'b0;
    end else begin
      code_ok_out <= (cnt_reg == BIT_CNT_W'(CMD_BITS - 1));
    end
  end

  // The word is held untouched until a later frame's thirty-second bit, so the
  // other domain may read it once the qualifying level has crossed.
  always_ff @(posedge spi_sclk_in) begin
    if (!spi_cs_n_in && cnt_reg == BIT_CNT_W'(CMD_BITS - 1)) begin
      code_out <= {shift_reg, spi_si_in};
    end
  end

endmodule : fsp_cmd_rx

// File: fsp_ctrl.sv
// Sector protection controller: flag, map, map erase and access checks.
`timescale 1ns/10ps
module fsp_ctrl #(
  parameter int unsigned ERASE_CYC = fsp_pkg::MAP_ERASE_CYC
) (
  input  wire logic                          sys_clk_in,
  input  wire logic                          rst_in,
  input  wire logic                          spi_sclk_in,
  input  wire logic                          spi_cs_n_in,
  input  wire logic                          spi_si_in,
  input  wire logic                          wp_n_in,
  input  wire logic                          map_factory_clr_in,
  input  wire logic                          map_wr_en_in,
  input  wire logic [fsp_pkg::MAP_IDX_W-1:0] map_wr_idx_in,
  input  wire logic [7:0]                    map_wr_data_in,
  input  wire logic [fsp_pkg::MAP_IDX_W-1:0] map_rd_idx_in,
  input  wire logic                          req_valid_in,
  input  wire logic [fsp_pkg::MAP_IDX_W-1:0] req_sector_in,
  input  wire logic [fsp_pkg::PAGE_W-1:0]    req_page_in,
  output logic [7:0]                         map_rd_data_out,
  output logic                               grant_out,
  output logic                               drop_out,
  output logic                               busy_out,
  output logic                               protect_on_out,
  output logic                               sw_enable_out,
  output logic                               wp_active_out
);
  import fsp_pkg::*;

  // True when the map marks this sector, or this part of sector 0.
  function automatic logic sector_marked(input logic [7:0] map_byte,
                                         input logic [MAP_IDX_W-1:0] sec,
                                         input logic [PAGE_W-1:0] page);
    logic res;
    res = 1'b0;
    if (sec != '0) begin
      res = (map_byte == MAP_ERASED);
    end else if (page < LOW_PART_PAGES) begin
      res = (map_byte[LOW_PART_MSB -: 2] == PART_PROT);
    end else begin
      res = (map_byte[HIGH_PART_MSB -: 2] == PART_PROT);
    end
    return res;
  endfunction : sector_marked

  // True when the word carries the shared three-byte prefix.
  function automatic logic has_prefix(input logic [31:0] word);
    return (word[31:8] == OP_PREFIX);
  endfunction : has_prefix

  logic [31:0]             code_word;
  logic                    code_ok;
  logic                    wp_active;
  logic                    cs_meta_reg;
  logic                    cs_sync_reg;
  logic                    cs_prev_reg;
  logic                    ok_meta_reg;
  logic                    ok_sync_reg;
  logic                    pend_reg;
  logic                    exec;
  logic                    cmd_enable;
  logic                    cmd_disable;
  logic                    cmd_erase;
  logic                    cmd_known;
  logic                    sw_flag_reg;
  logic                    sw_flag_next;
  logic                    prot_now;
  fsp_state_e              state_reg;
  fsp_state_e              state_next;
  logic [ERASE_CNT_W-1:0]  erase_cnt_reg;
  logic                    erase_done;
  logic                    erase_start;
  logic [7:0]              map_reg [MAP_BYTES];
  logic                    req_blocked;

  // Command words arrive on the host's clock.
  fsp_cmd_rx u_cmd_rx (
    .spi_sclk_in (spi_sclk_in),
    .spi_cs_n_in (spi_cs_n_in),
    .spi_si_in   (spi_si_in),
    .code_out    (code_word),
    .code_ok_out (code_ok)
  );

  // The pin is synchronised and filtered before it is believed.
  fsp_wp_filter u_wp_filter (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .wp_n_in       (wp_n_in),
    .wp_active_out (wp_active)
  );

  // Select and the frame-complete level each cross through two flops.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
      ok_meta_reg <= 1'b0;
      ok_sync_reg <= 1'b0;
    end else begin
      cs_meta_reg <= spi_cs_n_in;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
      ok_meta_reg <= code_ok;
      ok_sync_reg <= ok_meta_reg;
    end
  end

  // Both chains have the same depth, so the level seen one cycle before
  // the select rise still tells whether exactly four bytes arrived.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pend_reg <= 1'b0;
    end else if (!cs_sync_reg) begin
      pend_reg <= ok_sync_reg;
    end else begin
      pend_reg <= 1'b0;
    end
  end

  // Commands act on the release of select after the last bit.
  assign exec        = cs_sync_reg & ~cs_prev_reg & pend_reg;
  assign cmd_enable  = has_prefix(code_word)
                       && code_word[7:0] == OP_ENABLE;
  assign cmd_disable = has_prefix(code_word)
                       && code_word[7:0] == OP_DISABLE;
  assign cmd_erase   = has_prefix(code_word)
                       && code_word[7:0] == OP_MAP_ERASE;
  assign cmd_known   = cmd_enable | cmd_disable | cmd_erase;

  // Software flag; commands are not taken while the map erase runs.
  always_comb begin
    sw_flag_next = sw_flag_reg;
    if (exec && state_reg == FSP_ST_IDLE) begin
      if (cmd_enable) begin
        sw_flag_next = 1'b1;
      end else if (cmd_disable && !wp_active) begin
        sw_flag_next = 1'b0;
      end
    end
  end

  // Reset stands for power-up: protection by command is lost.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sw_flag_reg <= SW_FLAG_RST;
    end else begin
      sw_flag_reg <= sw_flag_next;
    end
  end

  // The pin adds protection on top of the flag; an enable taken while the
  // pin was low sets the flag, so release alone does not drop protection.
  assign prot_now = sw_flag_reg | wp_active;

  // Map erase runs whether protection is on or off, but not with the pin
  // asserted, because the map is then read only.
  assign erase_start = exec && cmd_erase && !wp_active
                       && state_reg == FSP_ST_IDLE;
  assign erase_done  = state_reg == FSP_ST_ERASE
                       && erase_cnt_reg == ERASE_CNT_W'(ERASE_CYC - 1);

  // Erase sequencer state.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FSP_ST_IDLE: begin
        if (erase_start) begin
          state_next = FSP_ST_ERASE;
        end
      end
      FSP_ST_ERASE: begin
        if (erase_done) begin
          state_next = FSP_ST_IDLE;
        end
      end
      default: begin
        state_next = FSP_ST_IDLE;
      end
    endcase
  end

  // State register and erase timer.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg     <= FSP_ST_IDLE;
      erase_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_reg == FSP_ST_ERASE && !erase_done) begin
        erase_cnt_reg <= erase_cnt_reg + 1'b1;
      end else begin
        erase_cnt_reg <= '0;
      end
    end
  end

  // The map is nonvolatile, so system reset leaves it alone. Programming
  // can only clear bits, which is why new contents need an erase first.
  always_ff @(posedge sys_clk_in) begin
    if (map_factory_clr_in) begin
      for (int i = 0; i < MAP_BYTES; i++) begin
        map_reg[i] <= MAP_FACTORY;
      end
    end else if (erase_done) begin
      for (int i = 0; i < MAP_BYTES; i++) begin
        map_reg[i] <= MAP_ERASED;
      end
    end else if (map_wr_en_in && !wp_active
                 && state_reg == FSP_ST_IDLE) begin
      map_reg[map_wr_idx_in] <= map_reg[map_wr_idx_in]
                                & map_wr_data_in;
    end
  end

  // Array program or erase requests; a marked sector under protection is
  // dropped with no answer beyond the drop pulse.
  assign req_blocked = prot_now
                       && sector_marked(map_reg[req_sector_in],
                                        req_sector_in,
                                        req_page_in);

  // Access decision, one pulse per request.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      grant_out <= 1'b0;
      drop_out  <= 1'b0;
    end else begin
      grant_out <= req_valid_in & ~req_blocked;
      drop_out  <= req_valid_in & req_blocked;
    end
  end

  // Status outputs, each straight from a flop.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      busy_out       <= 1'b0;
      protect_on_out <= 1'b0;
      sw_enable_out  <= SW_FLAG_RST;
      wp_active_out  <= 1'b0;
    end else begin
      busy_out       <= (state_next == FSP_ST_ERASE);
      protect_on_out <= sw_flag_next | wp_active;
      sw_enable_out  <= sw_flag_next;
      wp_active_out  <= wp_active;
    end
  end

  // Map read port for the status and read-back path.
  always_ff @(posedge sys_clk_in) begin
    map_rd_data_out <= map_reg[map_rd_idx_in];
  end

  // After reset release the flag reads clear.
  AST_FLAG_CLEAR_AT_POWERUP: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    $past(rst_in) |-> !sw_flag_reg && !sw_enable_out)
    else $error("software flag not clear after reset");

  // The filtered pin turns status protection on the next cycle.
  AST_PIN_FORCES_PROTECTION: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    wp_active |=> protect_on_out)
    else $error("asserted pin did not force protection");

  // Release of the pin with no flag and no enable drops status protection.
  AST_RELEASE_DROPS: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    $fell(wp_active) && !sw_flag_reg && !(exec && cmd_enable)
    |=> !protect_on_out)
    else $error("protection stayed after release without enable");

  // An enable taken while the pin is low survives the release.
  AST_ENABLE_SURVIVES_PIN: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    sw_flag_reg && !(exec && cmd_disable && !wp_active)
    |=> sw_flag_reg)
    else $error("flag lost without a disable command");

  // Disable while the pin is asserted leaves the flag as it was.
  AST_DISABLE_IGNORED_PIN: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exec && cmd_disable && wp_active |=> $stable(sw_flag_reg))
    else $error("disable acted while pin asserted");

  // Enable and disable act at deselect when idle and pin released.
  AST_ENABLE_DISABLE_ACT: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exec && !wp_active && state_reg == FSP_ST_IDLE
    && (cmd_enable || cmd_disable)
    |=> sw_flag_reg == $past(cmd_enable)
        && sw_enable_out == $past(cmd_enable))
    else $error("enable or disable did not take effect");

  // Map erase is refused while the pin is asserted.
  AST_ERASE_REFUSED_PIN: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exec && cmd_erase && wp_active && state_reg == FSP_ST_IDLE
    |=> state_reg == FSP_ST_IDLE && !busy_out)
    else $error("map erase started with pin asserted");

  // Accepted erase shows busy on the next cycle and stays busy for the cycle after it.
  AST_ERASE_BUSY: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    erase_start |=> busy_out [*2])
    else $error("busy not shown during map erase");

  // The end of the erase leaves the first and last map bytes at FFH.
  AST_ERASE_FILLS_MAP: assert property (
    @(posedge sys_clk_in) disable iff (rst_in || map_factory_clr_in)
    erase_done |=> map_reg[0] == MAP_ERASED
                   && map_reg[MAP_BYTES-1] == MAP_ERASED && !busy_out)
    else $error("map not erased to FFH");

  // A request to a protected, marked sector is dropped, never granted.
  AST_PROTECTED_DROPPED: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    req_valid_in && prot_now
    && sector_marked(map_reg[req_sector_in], req_sector_in, req_page_in)
    |=> drop_out && !grant_out)
    else $error("protected sector access was not dropped");

  // Unknown prefixed words change neither flag nor sequencer.
  AST_UNKNOWN_IGNORED: assert property (
    @(posedge sys_clk_in) disable iff (rst_in)
    exec && has_prefix(code_word) && !cmd_known
    && state_reg == FSP_ST_IDLE
    |=> $stable(sw_flag_reg) && state_reg == FSP_ST_IDLE)
    else $error("unknown command changed state");

endmodule : fsp_ctrl

// File: fsp_host_model.sv
// Serial host model that shifts four-byte command frames into the block.
`timescale 1ns/10ps
module fsp_host_model (
  output logic spi_sclk_out,
  output logic spi_cs_n_out,
  output logic spi_si_out
);
  // The serial clock stands low between frames and the host starts idle.
  initial begin
    spi_sclk_out = 1'b0;
    spi_cs_n_out = 1'b1;
    spi_si_out   = 1'b0;
  end

  // One frame: 32 bits MSB first, 12 ns link clock, then a deselect gap.
  task send(input logic [31:0] word);
    int i;
    spi_cs_n_out = 1'b0;
    for (i = 31; i >= 0; i--) begin
      spi_si_out   = word[i];
      #6 spi_sclk_out = 1'b1;
      #6 spi_sclk_out = 1'b0;
    end
    // Data line toggles so a stale bit is never mistaken for a held one.
    spi_si_out = ~spi_si_out;
    #30 spi_cs_n_out = 1'b1;
    spi_si_out = ~spi_si_out;
    #40;
  endtask : send
endmodule : fsp_host_model

// File: fsp_pkg.sv
// Shared constants and types for the flash sector protection controller.
package fsp_pkg;

  // System clock rate used to turn times into cycle counts.
  localparam int unsigned SYS_CLK_MHZ = 125;

  // Longest delay from a settled write-protect edge to the protection
  // change, in ns; the cycle counts round down.
  localparam int unsigned PROTECT_ASSERT_DELAY_NS  = 1000;
  localparam int unsigned PROTECT_RELEASE_DELAY_NS = 1000;
  localparam int unsigned PROTECT_ASSERT_CYC =
    (PROTECT_ASSERT_DELAY_NS * SYS_CLK_MHZ) / 1000;
  localparam int unsigned PROTECT_RELEASE_CYC =
    (PROTECT_RELEASE_DELAY_NS * SYS_CLK_MHZ) / 1000;

  // Least time the pin must hold a new level to be believed, in ns.
  localparam int unsigned WP_FILTER_NS  = 200;
  localparam int unsigned WP_FILTER_CYC =
    (WP_FILTER_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int unsigned WP_FILT_W     = 8;

  // Self-timed map erase, in us, and its cycle count.
  localparam int unsigned MAP_ERASE_TIME_US = 50;
  localparam int unsigned MAP_ERASE_CYC = MAP_ERASE_TIME_US * SYS_CLK_MHZ;
  localparam int unsigned ERASE_CNT_W   = 16;

  // Map geometry and byte values.
  localparam int unsigned MAP_BYTES    = 16;
  localparam int unsigned MAP_IDX_W    = 4;
  localparam int unsigned PAGE_W       = 8;
  localparam logic [7:0] LOW_PART_PAGES = 8'h08;
  localparam logic [7:0] MAP_ERASED     = 8'hFF;
  localparam logic [7:0] MAP_FACTORY    = 8'h00;
  localparam logic [1:0] PART_PROT      = 2'h3;
  localparam int unsigned LOW_PART_MSB  = 7;
  localparam int unsigned HIGH_PART_MSB = 5;

  // Four-byte command words, first byte in the top bits.
  localparam logic [23:0] OP_PREFIX    = 24'h3D2A7F;
  localparam logic [7:0]  OP_ENABLE    = 8'hA9;
  localparam logic [7:0]  OP_DISABLE   = 8'h9A;
  localparam logic [7:0]  OP_MAP_ERASE = 8'hCF;
  localparam int unsigned CMD_BITS     = 32;
  localparam int unsigned BIT_CNT_W    = 6;

  // Values after reset.
  localparam logic SW_FLAG_RST = 1'b0;
  localparam logic WP_IDLE_LVL = 1'b1;

  typedef enum {FSP_ST_IDLE, FSP_ST_ERASE} fsp_state_e;

endpackage : fsp_pkg

// File: fsp_wp_filter.sv
// Write-protect pin synchroniser and noise filter.
`timescale 1ns/10ps
module fsp_wp_filter (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        wp_n_in,
  output logic             wp_active_out
);
  import fsp_pkg::*;

  logic                    meta_reg;
  logic                    sync_reg;
  logic                    level_reg;
  logic [WP_FILT_W-1:0]    cnt_reg;

  // Two flops before any logic; the idle level is the pulled-up high.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      meta_reg <= WP_IDLE_LVL;
      sync_reg <= WP_IDLE_LVL;
    end else begin
      meta_reg <= wp_n_in;
      sync_reg <= meta_reg;
    end
  end

  // A new level must hold for the whole filter time; a short pulse only
  // restarts the count, so noise moves the output in neither direction.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      level_reg <= WP_IDLE_LVL;
      cnt_reg   <= '0;
    end else if (sync_reg == level_reg) begin
      cnt_reg   <= '0;
    end else if (cnt_reg == WP_FILT_W'(WP_FILTER_CYC - 1)) begin
      level_reg <= sync_reg;
      cnt_reg   <= '0;
    end else begin
      cnt_reg   <= cnt_reg + 1'b1;
    end
  end

  // A floating pin reads high and so never asserts protection.
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wp_active_out <= 1'b0;
    end else begin
      wp_active_out <= ~level_reg;
    end
  end

endmodule : fsp_wp_filter

// File: test_flash_sector_protection_ctrl.sv
// Self-checking bench for the sector protection controller.
`timescale 1ns/10ps
module test_flash_sector_protection_ctrl;
  import fsp_pkg::*;
  localparam int unsigned ERASE = 20;
  logic       sys_clk_in = 1'b0;
  logic       rst_in, wp_n_in, clr, wr_en, req_valid;
  logic       sclk, cs_n, si, grant, drop, busy, prot, sw_en, wp_act;
  logic [3:0] wr_idx, rd_idx, sec;
  logic [7:0] wr_data, page, rd_data;
  logic [1:0] notes[$];
  int         num_errors = 0;
  int         compares = 0;
  int         n;

  fsp_host_model u_fsp_host_model (.spi_sclk_out(sclk),
    .spi_cs_n_out(cs_n), .spi_si_out(si));
  fsp_ctrl #(.ERASE_CYC(ERASE)) u_fsp_ctrl (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n),
    .spi_si_in(si), .wp_n_in(wp_n_in), .map_factory_clr_in(clr),
    .map_wr_en_in(wr_en), .map_wr_idx_in(wr_idx),
    .map_wr_data_in(wr_data), .map_rd_idx_in(rd_idx),
    .req_valid_in(req_valid), .req_sector_in(sec), .req_page_in(page),
    .map_rd_data_out(rd_data), .grant_out(grant), .drop_out(drop),
    .busy_out(busy), .protect_on_out(prot), .sw_enable_out(sw_en),
    .wp_active_out(wp_act));

  // Clock of 8 ns.
  always #4 sys_clk_in = ~sys_clk_in;

  task stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task chk_req(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_req

  // Holds the request up; back-to-back calls give back-to-back requests.
  task req(input logic [3:0] s, input logic [7:0] p, input logic [1:0] e);
    @(negedge sys_clk_in);
    req_valid = 1'b1;
    sec       = s;
    page      = p;
    notes.push_back(e);
  endtask : req

  task idle();
    @(negedge sys_clk_in);
    req_valid = 1'b0;
  endtask : idle

  task wr_map(input logic [3:0] i, input logic [7:0] d);
    @(negedge sys_clk_in);
    wr_en   = 1'b1;
    wr_idx  = i;
    wr_data = d;
    @(negedge sys_clk_in);
    wr_en   = 1'b0;
  endtask : wr_map

  task rd_map(input logic [3:0] i, input logic [7:0] e);
    @(negedge sys_clk_in);
    rd_idx = i;
    repeat (2) @(posedge sys_clk_in);
    #1 chk(rd_data, e);
  endtask : rd_map

  task cmd(input logic [7:0] op);
    u_fsp_host_model.send({OP_PREFIX, op});
    repeat (8) @(posedge sys_clk_in);
    #1;
  endtask : cmd

  // The check lands no later than the longest allowed protection delay.
  task pin(input logic lvl);
    @(negedge sys_clk_in);
    wp_n_in = lvl;
    repeat (lvl ? PROTECT_RELEASE_CYC : PROTECT_ASSERT_CYC)
      @(posedge sys_clk_in);
    #1;
  endtask : pin

  // Each registered answer takes the oldest note of what was asked; the
  // falling edge is used so the answer has settled after its launch.
  always @(negedge sys_clk_in)
    if (grant === 1'b1 || drop === 1'b1) begin
      if (notes.size() == 0) chk_req({grant, drop}, 2'b00);
      else chk_req({grant, drop}, notes.pop_front());
    end

  // Watchdog sized well beyond the roughly 1200 cycles the run needs.
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    num_errors++;
    stop_test();
  end

  initial begin
    rst_in = 1'b1;
    wp_n_in = WP_IDLE_LVL;
    {clr, wr_en, req_valid, wr_idx, rd_idx, sec} = '0;
    {wr_data, page} = '0;
    void'($urandom(32'hC056));
    repeat (5) @(posedge sys_clk_in);
    @(negedge sys_clk_in) rst_in = 1'b0;
    @(posedge sys_clk_in) #1 chk(sw_en, 1'b0);
    chk(prot, 1'b0);
    @(negedge sys_clk_in) clr = 1'b1;
    @(negedge sys_clk_in) clr = 1'b0;
    for (int i = 0; i < 16; i++) rd_map(i[3:0], MAP_FACTORY);
    req(4'($urandom_range(15, 1)), 8'($urandom), 2'b10);
    idle();
    // Busy can rise before the frame task returns, so count alongside it.
    n = 0;
    fork
      u_fsp_host_model.send({OP_PREFIX, OP_MAP_ERASE});
      repeat (100) begin
        @(posedge sys_clk_in) #1 if (busy === 1'b1) n++;
      end
    join
    chk(n, ERASE);
    for (int i = 0; i < 16; i++) rd_map(i[3:0], MAP_ERASED);
    req(4'h5, 8'($urandom), 2'b10);
    idle();
    cmd(OP_ENABLE);
    chk(sw_en, 1'b1);
    chk(prot, 1'b1);
    req(4'h5, 8'($urandom), 2'b01);
    req(4'h0, 8'($urandom_range(7, 0)), 2'b01);
    req(4'h0, 8'($urandom_range(255, 8)), 2'b01);
    idle();
    wr_map(4'h5, MAP_FACTORY);
    wr_map(4'h0, 8'h3F);
    rd_map(4'h0, 8'h3F);
    req(4'h5, 8'($urandom), 2'b10);
    req(4'h0, 8'($urandom_range(7, 0)), 2'b10);
    req(4'h0, 8'($urandom_range(255, 8)), 2'b01);
    idle();
    wr_map(4'h5, MAP_ERASED);
    rd_map(4'h5, MAP_FACTORY);
    cmd(8'h55);
    chk(sw_en, 1'b1);
    cmd(OP_DISABLE);
    chk(prot, 1'b0);
    // A pulse shorter than the filter span must leave protection alone.
    @(negedge sys_clk_in) wp_n_in = 1'b0;
    repeat (10) @(negedge sys_clk_in);
    wp_n_in = 1'b1;
    repeat (40) @(posedge sys_clk_in);
    #1 chk({wp_act, prot}, 2'b00);
    pin(1'b0);
    chk({wp_act, prot}, 2'b11);
    wr_map(4'h0, MAP_FACTORY);
    rd_map(4'h0, 8'h3F);
    req(4'h0, 8'($urandom_range(255, 8)), 2'b01);
    idle();
    pin(1'b1);
    chk(prot, 1'b0);
    wr_map(4'h0, 8'h30);
    rd_map(4'h0, 8'h30);
    cmd(OP_ENABLE);
    pin(1'b0);
    cmd(OP_DISABLE);
    chk(sw_en, 1'b1);
    pin(1'b1);
    chk(prot, 1'b1);
    cmd(OP_DISABLE);
    chk(prot, 1'b0);
    chk(notes.size(), 0);
    stop_test();
  end
endmodule : test_flash_sector_protection_ctrl
